/* logic/fbms_pkg.sv */
// Functional notes
// R1 - Active flag sets on participation, stays set
// R2 - Active flag zero until slave first participates
// R3 - Error flag sets on withdrawal, clears on rejoin
// R4 - Error flag zero when normal or never joined
// R5 - All flags cleared at power-on and restart
// R6 - Stop mode halts I/O on any error; the code stops only on a slave withdrawal error, not on a verification error
// R7 - 8-node mode status at offsets 8, 9
// R8 - 16-node mode status at offsets 16 to 19
// R9 - Status block base 2000 plus unit times 10
// R10 - Config block base 20000 plus unit times 100
// R11 - Disconnection lights run, comm error; restart policy
// R12 - Verification error lights run, comm error, send
// R13 - Unit number fault lights host error only
// R14 - I/O enabled after startup and active flag
// R15 - Host keeps first ten config words reserved
// R16 - Status words read-only to the host
//
// Shared constants and carrier types of the fieldbus master status block.
// Assumes a 16-bit word-addressed host memory port in the sys_clk domain.
package fbms_pkg;

	localparam int unsigned NODES = 16;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 16;

	// Block bases and strides, word addresses
	localparam logic [15:0] STATUS_BASE = 16'h07d0;
	localparam logic [15:0] STATUS_STRIDE = 16'h000a;
	localparam logic [15:0] CONFIG_BASE = 16'h4e20;
	localparam logic [15:0] CONFIG_STRIDE = 16'h0064;
	localparam logic [6:0] UNIT_MAX = 7'h5f;

	// Status word offsets
	localparam logic [15:0] OFS_OUT_LO8 = 16'h0008;
	localparam logic [15:0] OFS_IN_LO8 = 16'h0009;
	localparam logic [15:0] OFS_OUT_LO16 = 16'h0010;
	localparam logic [15:0] OFS_IN_LO16 = 16'h0011;
	localparam logic [15:0] OFS_OUT_HI16 = 16'h0012;
	localparam logic [15:0] OFS_IN_HI16 = 16'h0013;

	// Configuration and diagnostic word offsets
	localparam logic [15:0] OFS_CFG_CTRL = 16'h0000;
	localparam logic [15:0] OFS_CFG_FLAGS = 16'h0004;
	localparam logic [15:0] OFS_CFG_STOPNODE = 16'h0005;
	localparam logic [15:0] CFG_WORDS = 16'h000a;

	// Control word fields
	localparam int unsigned CTRL_STOP_MODE_BIT = 0;
	localparam int unsigned CTRL_REG_EN_BIT = 1;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// Diagnostic flag word fields
	localparam int unsigned FLG_MISSING_BIT = 8;
	localparam int unsigned FLG_UNREG_BIT = 9;
	localparam int unsigned FLG_STOPPED_BIT = 10;
	localparam int unsigned FLG_ERROR_BIT = 15;
	localparam int unsigned STOP_TYPE_BIT = 15;

	localparam logic [15:0] STATUS_RESET = 16'h0000;

	typedef struct packed {
		logic [NODES-1:0] err;
		logic [NODES-1:0] act;
	} fbms_flags_s;

	typedef struct packed {
		logic run;
		logic host_err;
		logic comm_err;
		logic send;
	} fbms_ind_s;

endpackage

/* logic/fbms_slave_track.sv */
// Per-slave active and communications-error flags for one slave direction.
// Assumes part[] is a level from the link engine, high while a slave answers.
`timescale 1ns/1ps
module fbms_slave_track import fbms_pkg::*; (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic clr, // Unit restart, one cycle
	input wire logic node16, // 16-node addressing mode
	input wire logic [NODES-1:0] part, // Slave participating now
	output fbms_flags_s flags // Registered flags
);

	fbms_flags_s flags_r;
	fbms_flags_s flags_nxt;
	logic [NODES-1:0] usable;

	// Upper slaves are not addressable in 8-node mode
	assign usable = node16 ? {NODES{1'b1}} : {{(NODES/2){1'b0}}, {(NODES/2){1'b1}}};

	always_comb begin
		flags_nxt = flags_r;
		if (clr) begin
			// R5 restart clears flags
			flags_nxt = '0;
		end else begin
			for (int i = 0; i < NODES; i++) begin
				// R1 R2 sticky active flag
				flags_nxt.act[i] = flags_r.act[i] | (part[i] & usable[i]);
				// R3 R4 error only after a withdrawal
				flags_nxt.err[i] = flags_r.act[i] & usable[i] & ~part[i];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		// R5 power-on clear
		if (rst) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign flags = flags_r;

endmodule // fbms_slave_track

/* logic/fbms_indicator.sv */
// Front-panel indicator decode from the unit's error classes.
// Assumes error inputs are levels from the same clock domain.
`timescale 1ns/1ps
module fbms_indicator import fbms_pkg::*; (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic unit_err, // Unit number duplicated or out of range
	input wire logic comm_err, // Any slave withdrawn, or stopped
	input wire logic verif_err, // Missing or unregistered slave
	input wire logic link_ok, // Remote I/O running
	output fbms_ind_s ind // Registered indicator levels
);

	fbms_ind_s ind_r;
	fbms_ind_s ind_nxt;

	always_comb begin
		ind_nxt = '0;
		if (unit_err) begin
			// R13 host error only, run dark
			ind_nxt.host_err = 1'b1;
		end else if (verif_err) begin
			// R12 run, comm error and send
			ind_nxt.run = 1'b1;
			ind_nxt.comm_err = 1'b1;
			ind_nxt.send = 1'b1;
		end else if (comm_err) begin
			// R11 run and comm error
			ind_nxt.run = 1'b1;
			ind_nxt.comm_err = 1'b1;
		end else begin
			ind_nxt.run = 1'b1;
			ind_nxt.send = link_ok;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ind_r <= '0;
		end else begin
			ind_r <= ind_nxt;
		end
	end

	assign ind = ind_r;

endmodule // fbms_indicator

/* logic/fbms_master_status.sv */
// Fieldbus master status unit: slave flag tracking, status and diagnostic
// words on the host word port, communications-stop control and indicators.
// Assumes the host port and all slave levels are synchronous to sys_clk.
`timescale 1ns/1ps
module fbms_master_status import fbms_pkg::*; (
	input wire logic sys_clk, // 25 MHz system clock
	input wire logic rst, // Async reset, high (power-on)
	input wire logic unit_restart, // Unit restart request, one cycle
	input wire logic [6:0] unit_num, // Unit number switch
	input wire logic unit_dup, // Another unit uses this number
	input wire logic node16, // 16-node addressing mode switch
	input wire logic startup_done, // Link startup finished
	input wire logic [NODES-1:0] out_part, // Output slave participating
	input wire logic [NODES-1:0] in_part, // Input slave participating
	input wire logic verif_missing, // Registered slave missing
	input wire logic verif_unreg, // Unregistered slave seen
	input wire logic [ADDR_W-1:0] host_addr, // Host word address
	input wire logic host_rd, // Host read strobe
	input wire logic host_wr, // Host write strobe
	input wire logic [WORD_W-1:0] host_wdata, // Host write data
	output logic [WORD_W-1:0] host_rdata, // Read data, registered
	output logic host_ack, // Access answered, one cycle
	output logic [NODES-1:0] out_io_en, // Output slave data enabled
	output logic [NODES-1:0] in_io_en, // Input slave data enabled
	output logic comm_halt, // Remote I/O halted
	output logic link_restart, // Automatic link restart, one cycle
	output logic run_indicator, // Run lamp
	output logic host_error_indicator, // Host error lamp
	output logic comm_error_indicator, // Communications error lamp
	output logic send_indicator // Send lamp
);

	typedef struct packed {
		logic started;
		logic stopped;
		logic [7:0] stop_node;
		logic stop_in;
		logic unreg_seen;
		logic miss_q;
		logic any_err_q;
		logic [WORD_W-1:0] ctrl;
		logic [WORD_W-1:0] rdata;
		logic ack;
		logic restart;
	} fbms_main_s;

	fbms_main_s st_r;
	fbms_main_s st_nxt;
	fbms_flags_s out_flags;
	fbms_flags_s in_flags;
	fbms_ind_s ind;
	logic [ADDR_W-1:0] status_base;
	logic [ADDR_W-1:0] config_base;
	logic [ADDR_W-1:0] status_ofs;
	logic [ADDR_W-1:0] config_ofs;
	logic in_status;
	logic in_config;
	logic unit_err;
	logic any_out_err;
	logic any_in_err;
	logic any_err;
	logic verif_err;
	logic stop_mode;
	logic [WORD_W-1:0] diag_flags;
	logic [WORD_W-1:0] rd_word;
	logic rd_hit;
	logic io_gate;
	logic lamp_comm;
	logic lamp_link;

	// One status word: error flags high byte, active flags low byte
	function automatic logic [WORD_W-1:0] pack_status(input fbms_flags_s f, input logic upper);
		logic [7:0] a;
		logic [7:0] e;
		a = upper ? f.act[15:8] : f.act[7:0];
		e = upper ? f.err[15:8] : f.err[7:0];
		return {e, a};
	endfunction

	// Lowest slave index with an error, for the stop record
	function automatic logic [7:0] first_set(input logic [NODES-1:0] v);
		logic [7:0] idx;
		idx = 8'h00;
		// Walk downwards so the lowest index is left last
		for (int i = NODES - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 8'(i);
			end
		end
		return idx;
	endfunction

	fbms_slave_track u_out_track (
		.sys_clk(sys_clk),
		.rst(rst),
		.clr(unit_restart),
		.node16(node16),
		.part(out_part),
		.flags(out_flags)
	);

	fbms_slave_track u_in_track (
		.sys_clk(sys_clk),
		.rst(rst),
		.clr(unit_restart),
		.node16(node16),
		.part(in_part),
		.flags(in_flags)
	);

	// R9 status block base
	assign status_base = STATUS_BASE + 16'(unit_num) * STATUS_STRIDE;
	// R10 config block base
	assign config_base = CONFIG_BASE + 16'(unit_num) * CONFIG_STRIDE;
	assign status_ofs = host_addr - status_base;
	assign config_ofs = host_addr - config_base;
	// Offsets wrap high below the base, so the upper compare alone rejects them
	assign in_status = (host_addr >= status_base) && (status_ofs <= OFS_IN_HI16);
	assign in_config = (host_addr >= config_base) && (config_ofs < CFG_WORDS);

	// R13 unit number fault
	assign unit_err = unit_dup || (unit_num > UNIT_MAX);
	assign any_out_err = |out_flags.err;
	assign any_in_err = |in_flags.err;
	assign any_err = any_out_err | any_in_err;
	assign stop_mode = st_r.ctrl[CTRL_STOP_MODE_BIT];
	assign verif_err = st_r.ctrl[CTRL_REG_EN_BIT] & (verif_missing | st_r.unreg_seen);

	always_comb begin
		diag_flags = '0;
		diag_flags[FLG_MISSING_BIT] = st_r.ctrl[CTRL_REG_EN_BIT] & verif_missing;
		diag_flags[FLG_UNREG_BIT] = st_r.ctrl[CTRL_REG_EN_BIT] & st_r.unreg_seen;
		diag_flags[FLG_STOPPED_BIT] = st_r.stopped;
		// Summary bit follows the three cause bits
		diag_flags[FLG_ERROR_BIT] = |diag_flags[FLG_STOPPED_BIT:FLG_MISSING_BIT];
	end

	// Read decode; offsets per addressing mode
	always_comb begin
		rd_word = '0;
		rd_hit = 1'b0;
		if (in_status) begin
			// Upper slave words answer only in 16-node mode
			if (!node16) begin
				// R7 8-node layout
				case (status_ofs)
					OFS_OUT_LO8: begin
						rd_word = pack_status(out_flags, 1'b0);
						rd_hit = 1'b1;
					end
					OFS_IN_LO8: begin
						rd_word = pack_status(in_flags, 1'b0);
						rd_hit = 1'b1;
					end
					default: rd_hit = 1'b0;
				endcase
			end else begin
				// R8 16-node layout
				case (status_ofs)
					OFS_OUT_LO16: begin
						rd_word = pack_status(out_flags, 1'b0);
						rd_hit = 1'b1;
					end
					OFS_IN_LO16: begin
						rd_word = pack_status(in_flags, 1'b0);
						rd_hit = 1'b1;
					end
					OFS_OUT_HI16: begin
						rd_word = pack_status(out_flags, 1'b1);
						rd_hit = 1'b1;
					end
					OFS_IN_HI16: begin
						rd_word = pack_status(in_flags, 1'b1);
						rd_hit = 1'b1;
					end
					default: rd_hit = 1'b0;
				endcase
			end
		end else if (in_config) begin
			rd_hit = 1'b1;
			case (config_ofs)
				OFS_CFG_CTRL: rd_word = st_r.ctrl;
				OFS_CFG_FLAGS: rd_word = diag_flags;
				OFS_CFG_STOPNODE: begin
					rd_word[7:0] = st_r.stop_node;
					rd_word[STOP_TYPE_BIT] = st_r.stop_in;
				end
				// Other words of the block read as zero
				default: rd_word = '0;
			endcase
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = 1'b0;
		st_nxt.restart = 1'b0;
		// Edge detectors for the restart triggers
		st_nxt.miss_q = verif_missing;
		st_nxt.any_err_q = any_err;
		// Read wins if both strobes come together; rdata holds until next read
		if (host_rd) begin
			st_nxt.rdata = rd_word;
			st_nxt.ack = rd_hit;
		end else if (host_wr) begin
			// R16 status words ignore writes
			// Unmapped words get no ack at all
			st_nxt.ack = in_config | rd_hit;
			// R15 host owns only the control word here
			if (in_config && config_ofs == OFS_CFG_CTRL) begin
				st_nxt.ctrl = host_wdata;
			end
		end
		// Startup refused while the unit number is bad
		if (startup_done && !unit_err) begin
			st_nxt.started = 1'b1;
		end
		// Unregistered slave latches until restart
		if (verif_unreg) begin
			st_nxt.unreg_seen = 1'b1;
		end
		// R6 stop mode halts on first error
		if (stop_mode && any_err && !st_r.stopped) begin
			st_nxt.stopped = 1'b1;
			st_nxt.stop_in = ~any_out_err;
			st_nxt.stop_node = any_out_err ? first_set(out_flags.err) : first_set(in_flags.err);
		end
		// R11 normal mode restarts by itself
		if (!stop_mode && any_err && !st_r.any_err_q) begin
			st_nxt.restart = 1'b1;
		end
		// R12 missing slave back, restart
		if (st_r.miss_q && !verif_missing && !st_r.unreg_seen) begin
			st_nxt.restart = 1'b1;
		end
		// R5 unit restart clears latched state
		// Restart wins over every trigger above
		if (unit_restart) begin
			st_nxt.started = 1'b0;
			st_nxt.stopped = 1'b0;
			st_nxt.stop_node = '0;
			st_nxt.stop_in = 1'b0;
			st_nxt.unreg_seen = 1'b0;
			st_nxt.restart = 1'b0;
		end
	end

	// Power-on state; only this clears the control word
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r <= '{
				started: 1'b0,
				stopped: 1'b0,
				stop_node: 8'h00,
				stop_in: 1'b0,
				unreg_seen: 1'b0,
				miss_q: 1'b0,
				any_err_q: 1'b0,
				ctrl: CTRL_RESET,
				rdata: STATUS_RESET,
				ack: 1'b0,
				restart: 1'b0
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Halt keeps the comm lamp lit after the flags clear
	assign lamp_comm = any_err | st_r.stopped;
	assign lamp_link = st_r.started & ~st_r.stopped;

	fbms_indicator u_ind (
		.sys_clk(sys_clk),
		.rst(rst),
		.unit_err(unit_err),
		.comm_err(lamp_comm),
		.verif_err(verif_err),
		.link_ok(lamp_link),
		.ind(ind)
	);

	// R6 halted link holds data exchange off
	assign comm_halt = st_r.stopped | unit_err;
	// R14 data only after startup and activity
	assign io_gate = st_r.started & ~comm_halt;

	generate
		for (genvar g = 0; g < NODES; g++) begin : g_io_en
			assign out_io_en[g] = io_gate & out_flags.act[g];
			assign in_io_en[g] = io_gate & in_flags.act[g];
		end
	endgenerate
	assign link_restart = st_r.restart;
	assign host_rdata = st_r.rdata;
	assign host_ack = st_r.ack;
	assign run_indicator = ind.run;
	assign host_error_indicator = ind.host_err;
	assign comm_error_indicator = ind.comm_err;
	assign send_indicator = ind.send;

endmodule // fbms_master_status

/* sim/fbms_master_status_props.sv */
// Port checker for the fieldbus master status unit.
// Assumes the unit number is steady whenever the host reads.
`timescale 1ns/1ps
module fbms_master_status_props import fbms_pkg::*; (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic unit_restart, // Restart
	input wire logic [6:0] unit_num, // Unit
	input wire logic unit_dup, // Duplicate
	input wire logic node16, // Mode
	input wire logic verif_missing, // Missing
	input wire logic [ADDR_W-1:0] host_addr, // Address
	input wire logic host_rd, // Read
	input wire logic host_wr, // Write
	input wire logic [WORD_W-1:0] host_wdata, // Write data
	input wire logic [WORD_W-1:0] host_rdata, // Data
	input wire logic host_ack, // Ack
	input wire logic [NODES-1:0] out_io_en, // Out enable
	input wire logic [NODES-1:0] in_io_en, // In enable
	input wire logic run_indicator, // Run
	input wire logic host_error_indicator, // Host error
	input wire logic comm_error_indicator, // Comm error
	input wire logic send_indicator // Send
);
	logic [15:0] sb;
	assign sb = STATUS_BASE + STATUS_STRIDE * {9'h000, unit_num};
	logic [15:0] cb;
	logic reg_en_r;
	assign cb = CONFIG_BASE + CONFIG_STRIDE * {9'h000, unit_num};
	// Mirror of the registration enable bit, taken from host writes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_en_r <= 1'b0;
		end else if (host_wr && !host_rd && host_addr == cb + OFS_CFG_CTRL) begin
			reg_en_r <= host_wdata[CTRL_REG_EN_BIT];
		end
	end
	default clocking ck @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_rd_hit;
		host_rd && !node16 && host_addr == sb + OFS_OUT_LO8;
	endsequence
	sequence s_unit_fault;
		(unit_dup || unit_num > UNIT_MAX) [*2];
	endsequence
	a_read_hit_ack: assert property (s_rd_hit |=> host_ack)
		else $error("Mapped status read not acknowledged");
	a_unmapped_silent: assert property (host_rd && host_addr == sb |=> !host_ack && host_rdata == 16'h0000)
		else $error("Unmapped read answered");
	a_status_wr_ack: assert property (host_wr && !host_rd && !node16 && host_addr == sb + OFS_OUT_LO8 |=> host_ack)
		else $error("Status write not acknowledged");
	a_unit_fault_lamp: assert property (s_unit_fault |-> host_error_indicator && !run_indicator)
		else $error("Unit fault lamp wrong");
	a_host_err_only: assert property (host_error_indicator |-> !run_indicator && !comm_error_indicator && !send_indicator)
		else $error("Host error lamp not alone");
	a_comm_lamp_run: assert property (comm_error_indicator |-> run_indicator)
		else $error("Comm error lamp without run");
	a_node8_upper_off: assert property (!node16 |-> out_io_en[15:8] == 8'h00 && in_io_en[15:8] == 8'h00)
		else $error("Upper slaves enabled in 8-node mode");
	a_restart_clears: assert property (unit_restart |=> out_io_en == 16'h0000 && in_io_en == 16'h0000)
		else $error("Restart left slaves enabled");
	a_verif_lamps: assert property ((reg_en_r && verif_missing && !unit_dup && unit_num <= UNIT_MAX) [*3] |-> run_indicator && comm_error_indicator && send_indicator)
		else $error("Verification lamps wrong");
endmodule // fbms_master_status_props
bind fbms_master_status fbms_master_status_props u_props (.sys_clk, .rst, .unit_restart, .unit_num,
	.unit_dup, .node16, .verif_missing, .host_addr, .host_rd, .host_wr, .host_wdata, .host_rdata,
	.host_ack,
	.out_io_en, .in_io_en, .run_indicator, .host_error_indicator, .comm_error_indicator,
	.send_indicator);

/* sim/fbms_slave_model.sv */
// Behavioural fieldbus slaves on the far side of the link.
// Assumes the bench says which slaves should be on the line.
`timescale 1ns/1ps
module fbms_slave_model import fbms_pkg::*; (
	input wire logic sys_clk, // Clock
	input wire logic [NODES-1:0] out_want, // Output slaves to attach
	input wire logic [NODES-1:0] in_want, // Input slaves to attach
	output logic [NODES-1:0] out_part, // Output slaves answering
	output logic [NODES-1:0] in_part // Input slaves answering
);
	// One poll of lag, as a slave only shows up on the next cycle
	always_ff @(posedge sys_clk) begin
		out_part <= out_want;
		in_part <= in_want;
	end
endmodule // fbms_slave_model

/* sim/fbms_master_status_bench.sv */
// Testbench for the fieldbus master status unit.
// Host word port driven here; slaves come from the partner model.
`timescale 1ns/1ps
module fbms_master_status_bench import fbms_pkg::*;;
	logic sys_clk = 0, rst = 1, unit_restart = 0, unit_dup = 0, node16 = 0, startup_done = 0;
	logic verif_missing = 0, verif_unreg = 0, host_rd = 0, host_wr = 0;
	logic [6:0] unit_num = 7'h03;
	logic [15:0] host_addr = 16'h0000, host_wdata = 16'h0000, ow = 16'h0000, iw = 16'h0000;
	logic [15:0] out_part, in_part, host_rdata, out_io_en, in_io_en, sb, cb;
	logic host_ack, comm_halt, link_restart, run_indicator, host_error_indicator;
	logic comm_error_indicator, send_indicator;
	int n_mismatch = 0, cmp_count = 0;
	always #20 sys_clk = ~sys_clk;
	fbms_master_status u_fbms_master_status (.sys_clk, .rst, .unit_restart, .unit_num, .unit_dup,
		.node16, .startup_done, .out_part, .in_part, .verif_missing, .verif_unreg, .host_addr,
		.host_rd, .host_wr, .host_wdata, .host_rdata, .host_ack, .out_io_en, .in_io_en,
		.comm_halt, .link_restart, .run_indicator, .host_error_indicator,
		.comm_error_indicator, .send_indicator);
	fbms_slave_model u_fbms_slave_model (.sys_clk, .out_want(ow), .in_want(iw), .out_part,
		.in_part);
	task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task rd(input logic [15:0] a, input logic ak, input logic [15:0] e);
		host_addr = a;
		host_rd = 1;
		cyc(1);
		host_rd = 0;
		chk("host_ack", {15'h0, ak}, {15'h0, host_ack});
		chk("host_rdata", e, host_rdata);
		cyc(1);
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		host_addr = a;
		host_wdata = d;
		host_wr = 1;
		cyc(1);
		host_wr = 0;
		chk("host_ack", 16'h0001, {15'h0, host_ack});
	endtask
	task lamps(input logic [3:0] e);
		chk("lamps", {12'h0, e}, {12'h0, run_indicator, host_error_indicator,
			comm_error_indicator, send_indicator});
	endtask
	task seen_restart(input logic e);
		logic got;
		got = 0;
		repeat (6) begin
			cyc(1);
			got = got | link_restart;
		end
		chk("link_restart", {15'h0, e}, {15'h0, got});
	endtask
	task pulse_restart;
		unit_restart = 1;
		cyc(1);
		unit_restart = 0;
		cyc(3);
	endtask
	task test_done;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_mismatch++;
		test_done;
	end
	initial begin
		sb = STATUS_BASE + STATUS_STRIDE * 16'h0003;
		cb = CONFIG_BASE + CONFIG_STRIDE * 16'h0003;
		cyc(8);
		rst = 0;
		rd(sb + OFS_OUT_LO8, 1, 16'h0000);
		rd(sb + OFS_IN_LO8, 1, 16'h0000);
		startup_done = 1;
		ow = 16'h0208;
		iw = 16'h0001;
		cyc(3);
		rd(sb + OFS_OUT_LO8, 1, 16'h0008);
		rd(sb + OFS_IN_LO8, 1, 16'h0001);
		chk("out_io_en", 16'h0008, out_io_en);
		wr(sb + OFS_OUT_LO8, 16'hffff);
		rd(sb + OFS_OUT_LO8, 1, 16'h0008);
		rd(sb, 0, 16'h0000);
		ow = 16'h0000;
		seen_restart(1);
		rd(sb + OFS_OUT_LO8, 1, 16'h0808);
		lamps(4'b1010);
		ow = 16'h0008;
		cyc(3);
		rd(sb + OFS_OUT_LO8, 1, 16'h0008);
		lamps(4'b1001);
		// Only the control word is written, the rest of the block stays reserved
		wr(cb + OFS_CFG_CTRL, 16'h0001);
		ow = 16'h0028;
		cyc(3);
		ow = 16'h0008;
		cyc(4);
		chk("comm_halt", 16'h0001, {15'h0, comm_halt});
		seen_restart(0);
		rd(cb + OFS_CFG_FLAGS, 1, 16'h8400);
		rd(cb + OFS_CFG_STOPNODE, 1, 16'h0005);
		lamps(4'b1010);
		pulse_restart;
		chk("comm_halt", 16'h0000, {15'h0, comm_halt});
		rd(sb + OFS_OUT_LO8, 1, 16'h0008);
		rd(cb + OFS_CFG_CTRL, 1, 16'h0001);
		wr(cb + OFS_CFG_CTRL, 16'h0002);
		verif_missing = 1;
		cyc(4);
		lamps(4'b1011);
		rd(cb + OFS_CFG_FLAGS, 1, 16'h8100);
		verif_missing = 0;
		seen_restart(1);
		verif_unreg = 1;
		cyc(2);
		verif_unreg = 0;
		seen_restart(0);
		lamps(4'b1011);
		pulse_restart;
		lamps(4'b1001);
		unit_dup = 1;
		cyc(3);
		lamps(4'b0100);
		chk("comm_halt", 16'h0001, {15'h0, comm_halt});
		unit_dup = 0;
		unit_num = 7'h60;
		cyc(3);
		lamps(4'b0100);
		unit_num = 7'h5f;
		cyc(3);
		lamps(4'b1001);
		unit_num = 7'h03;
		rst = 1;
		node16 = 1;
		ow = 16'h0200;
		iw = 16'h1000;
		cyc(2);
		rst = 0;
		cyc(4);
		rd(sb + OFS_OUT_HI16, 1, 16'h0002);
		rd(sb + OFS_IN_HI16, 1, 16'h0010);
		rd(sb + OFS_OUT_LO16, 1, 16'h0000);
		rd(sb + OFS_OUT_LO8, 0, 16'h0000);
		chk("in_io_en", 16'h1000, in_io_en);
		test_done;
	end
endmodule // fbms_master_status_bench
